// File: hw/ise_top.sv
/*
  Status, event flag and wake logic of a two-wire bus interface.
  Assumes a bus shift engine on link_clk_in that reports events as
  one-cycle pulses, and a CPU on core_clk_in that owns the register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ise_regs.svh"
module ise_top
  import ise_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SYNC_STAGES = 2
)
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  input wire logic ev_start_done_in,
  input wire logic ev_byte_done_in,
  input wire logic ev_addr_hit_in,
  input wire logic ev_ten_bit_header_sent_in,
  input wire logic ev_ack_missing_in,
  input wire logic ev_arb_lost_in,
  input wire logic ev_gc_addr_in,
  input wire logic ev_ack_seen_in,
  input wire logic mid_byte_in,
  input wire logic master_rx_in,
  input wire logic ack_slot_in,
  input wire logic wait_in,
  input wire logic halt_in,
  input wire logic cpu_mask_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rd_data_out,
  output logic irq_req_out,
  output logic wake_out,
  output logic ack_hold_off_out,
  output logic start_req_out,
  output logic [7:0] data_byte_out,
  output logic data_wr_out
);

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 2 || ADDR_W > 8)
  begin : g_bad_addr
    $error("ADDR_W must lie in 2..8");
  end
  if (SYNC_STAGES != 2)
  begin : g_bad_sync
    $error("SYNC_STAGES must be 2");
  end

  localparam int NEV = `ISE_NUM_EV;

  // core-side state comes first: the link side samples some of it
  ise_pwr_t pwr_q;
  ise_pwr_t pwr_d;
  logic frozen;
  logic irq_any;
  ise_ctrl_t ctrl_q;
  ise_ctrl_t ctrl_d;
  ise_st1_t st1_q;
  ise_st1_t st1_d;
  ise_st2_t st2_q;
  ise_st2_t st2_d;
  logic start_tgl_q;
  logic master_q;
  logic sr1_armed_q;
  logic [7:0] rd_data_q;
  logic [7:0] rd_mux;
  logic [7:0] data_byte_q;
  logic data_wr_q;
  logic irq_q;
  logic wake_q;
  logic scl_oe_n_q;
  logic ack_off_q;
  logic [7:0] addr8;
  logic acc_ok;
  logic wr_ctrl;
  logic wr_data;
  logic rd_st1;
  logic rd_st2;
  logic start_go;
  logic clr_sr1;
  logic on;

  // ==========================================================
  // link domain: reset, pin sampling, condition detection
  logic [1:0] lrst_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [2:0] lvl_s1_q;
  logic [2:0] lvl_s2_q;
  logic [2:0] st_s_q;
  logic after_ack_q;
  logic start_req_q;
  logic [NEV-1:0] ltgl_q;
  logic link_rst_n;
  logic scl_hi;
  logic start_cond;
  logic stop_cond;
  logic on_l;
  logic ack_en_l;
  logic master_l;
  logic [NEV-1:0] ev_raw;

  // the reset pin reaches the link side through two flops of its own
  always_ff @(posedge link_clk_in)
  begin
    lrst_q <= {lrst_q[0], reset_n_in};
  end
  assign link_rst_n = lrst_q[1];

  // bus pins and core levels each pass two flops; stage three is for edges
  always_ff @(posedge link_clk_in)
  begin
    if (!link_rst_n)
    begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_s3_q <= 2'h3;
      lvl_s1_q <= 3'h0;
      lvl_s2_q <= 3'h0;
    end
    else
    begin
      pin_s1_q <= {scl_in, sda_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      lvl_s1_q <= {master_q, ctrl_q.ack_en, ctrl_q.on};
      lvl_s2_q <= lvl_s1_q;
    end
  end

  assign on_l = lvl_s2_q[0];
  assign ack_en_l = lvl_s2_q[1];
  assign master_l = lvl_s2_q[2];
  // start: data falls while clock high; stop: data rises while clock high
  assign scl_hi = pin_s2_q[1] & pin_s3_q[1];
  assign start_cond = scl_hi & pin_s3_q[0] & ~pin_s2_q[0];
  assign stop_cond = scl_hi & ~pin_s3_q[0] & pin_s2_q[0];

  // raw bus events, dropped while the interface is off
  assign ev_raw[`ISE_EV_START_DONE] = on_l & ev_start_done_in;
  assign ev_raw[`ISE_EV_BYTE_DONE] = on_l & ev_byte_done_in;
  assign ev_raw[`ISE_EV_ADDR_HIT] = on_l & ev_addr_hit_in;
  assign ev_raw[`ISE_EV_TEN_BIT_HEADER_SENT] = on_l & ev_ten_bit_header_sent_in;
  assign ev_raw[`ISE_EV_ACK_MISSING] = on_l & ev_ack_missing_in;
  assign ev_raw[`ISE_EV_STOP_SEEN] = on_l & stop_cond & after_ack_q
    & ack_en_l & ~master_l;
  // the ack bit of a master receive is never arbitrated
  assign ev_raw[`ISE_EV_ARB_LOST] = on_l & ev_arb_lost_in
    & ~(master_rx_in & ack_slot_in);
  assign ev_raw[`ISE_EV_BUS_FAULT] = on_l & (start_cond | stop_cond)
    & mid_byte_in;
  assign ev_raw[`ISE_EV_GC_HIT] = on_l & ev_gc_addr_in;
  assign ev_raw[`ISE_EV_STOP_ANY] = on_l & stop_cond;

  // remembers that the last bus bit was an acknowledge
  always_ff @(posedge link_clk_in)
  begin
    if (!link_rst_n)
      after_ack_q <= 1'b0;
    else if (ev_ack_seen_in)
      after_ack_q <= 1'b1;
    else if (start_cond || stop_cond || ev_byte_done_in)
      after_ack_q <= 1'b0;
  end

  // start request arrives as a toggle and leaves as a one-cycle pulse
  always_ff @(posedge link_clk_in)
  begin
    if (!link_rst_n)
    begin
      st_s_q <= 3'h0;
      start_req_q <= 1'b0;
    end
    else
    begin
      st_s_q <= {st_s_q[1:0], start_tgl_q};
      start_req_q <= st_s_q[1] ^ st_s_q[2];
    end
  end
  assign start_req_out = start_req_q;

  // ==========================================================
  // event crossing: one toggle per event, three flops on the core side
  logic [NEV-1:0] ev_c;
  for (genvar i = 0; i < NEV; i++)
  begin : g_ev
    logic c1_q;
    logic c2_q;
    logic c3_q;
    always_ff @(posedge link_clk_in)
    begin
      if (!link_rst_n)
        ltgl_q[i] <= 1'b0;
      else if (ev_raw[i])
        ltgl_q[i] <= ~ltgl_q[i];
    end
    // in halt stage three holds, so an event is taken on wake, not lost
    always_ff @(posedge core_clk_in)
    begin
      if (!reset_n_in)
      begin
        c1_q <= 1'b0;
        c2_q <= 1'b0;
        c3_q <= 1'b0;
      end
      else
      begin
        c1_q <= ltgl_q[i];
        c2_q <= c1_q;
        c3_q <= frozen ? c3_q : c2_q;
      end
    end
    assign ev_c[i] = ~frozen & (c2_q ^ c3_q);
  end

  // ==========================================================
  // core domain: power state
  // halt ends only when the CPU leaves halt by another wake source
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      ISE_PWR_RUN:
        if (halt_in)
          pwr_d = ISE_PWR_HALT;
        else if (wait_in)
          pwr_d = ISE_PWR_WAIT;
      ISE_PWR_WAIT:
        if (!wait_in)
          pwr_d = ISE_PWR_RUN;
      ISE_PWR_HALT:
        if (!halt_in)
          pwr_d = ISE_PWR_RUN;
      default:
        pwr_d = ISE_PWR_RUN;
    endcase
  end
  assign frozen = (pwr_q == ISE_PWR_HALT);

  // ==========================================================
  // register port decode
  assign addr8 = 8'(addr_in);
  assign acc_ok = ~frozen;
  assign wr_ctrl = acc_ok & wr_in & (addr8 == `ISE_OFF_CTRL);
  assign wr_data = acc_ok & wr_in & (addr8 == `ISE_OFF_DATA);
  assign rd_st1 = acc_ok & rd_in & (addr8 == `ISE_OFF_STATUS_ONE);
  assign rd_st2 = acc_ok & rd_in & (addr8 == `ISE_OFF_STATUS_TWO);
  assign on = ctrl_q.on;
  // a start request needs the interface already on
  assign start_go = wr_ctrl & wdata_in[`ISE_CTRL_START] & on;
  // clearing sequence: status one read, then a data register write
  assign clr_sr1 = wr_data & sr1_armed_q;

  // unmapped addresses read as zero; status two upper bits are zero
  assign rd_mux =
    (addr8 == `ISE_OFF_CTRL) ? {3'h0, ctrl_q.ack_en, ctrl_q.bcast_en,
      1'b0, ctrl_q.irq_en, ctrl_q.on} :
    (addr8 == `ISE_OFF_STATUS_ONE) ? {3'h0, st1_q} :
    (addr8 == `ISE_OFF_STATUS_TWO) ? {3'h0, st2_q} :
    (addr8 == `ISE_OFF_DATA) ? data_byte_q : 8'h00;

  // ==========================================================
  // flag next state: set beats clear, disable clears everything
  always_comb
  begin
    ctrl_d = ctrl_q;
    st1_d = st1_q;
    st2_d = st2_q;
    if (wr_ctrl)
    begin
      ctrl_d.on = wdata_in[`ISE_CTRL_ON];
      ctrl_d.irq_en = wdata_in[`ISE_CTRL_IRQ_EN];
      ctrl_d.bcast_en = wdata_in[`ISE_CTRL_BCAST_EN];
      ctrl_d.ack_en = wdata_in[`ISE_CTRL_ACK_EN];
    end
    if (!frozen)
    begin
      st1_d.sb = ev_c[`ISE_EV_START_DONE] | (st1_q.sb & ~clr_sr1);
      st1_d.byte_done_flag = ev_c[`ISE_EV_BYTE_DONE] | (st1_q.byte_done_flag & ~clr_sr1);
      st1_d.own_address_hit = ev_c[`ISE_EV_ADDR_HIT] | (st1_q.own_address_hit & ~clr_sr1);
      st1_d.ten_bit_header_sent = ev_c[`ISE_EV_TEN_BIT_HEADER_SENT] | (st1_q.ten_bit_header_sent & ~clr_sr1);
      // master role: set on request, cleared by stop or lost arbitration
      st1_d.master = start_go | (st1_q.master & ~ev_c[`ISE_EV_STOP_ANY]
        & ~ev_c[`ISE_EV_ARB_LOST]);
      st2_d.af = ev_c[`ISE_EV_ACK_MISSING] | (st2_q.af & ~rd_st2);
      st2_d.stop_seen_flag = ev_c[`ISE_EV_STOP_SEEN]
        | (st2_q.stop_seen_flag & ~rd_st2);
      st2_d.arbitration_lost_flag = ev_c[`ISE_EV_ARB_LOST] | (st2_q.arbitration_lost_flag & ~rd_st2);
      st2_d.bus_fault_flag = ev_c[`ISE_EV_BUS_FAULT] | (st2_q.bus_fault_flag & ~rd_st2);
      // general call only counts in slave role with acceptance on
      st2_d.broadcast_hit_flag = (ev_c[`ISE_EV_GC_HIT] & ctrl_q.bcast_en & ~st1_q.master)
        | (st2_q.broadcast_hit_flag & ~ev_c[`ISE_EV_STOP_ANY]);
    end
    if (!ctrl_d.on)
    begin
      st1_d = '0;
      st2_d = '0;
    end
  end

  // ==========================================================
  // core registers
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      pwr_q <= ISE_PWR_RUN;
      ctrl_q <= 4'(`ISE_CTRL_RESET);
      st1_q <= '0;
      st2_q <= 5'(`ISE_STATUS_TWO_RESET);
      sr1_armed_q <= 1'b0;
      start_tgl_q <= 1'b0;
      data_byte_q <= 8'h00;
      data_wr_q <= 1'b0;
      rd_data_q <= 8'h00;
    end
    else
    begin
      pwr_q <= pwr_d;
      ctrl_q <= ctrl_d;
      st1_q <= st1_d;
      st2_q <= st2_d;
      if (rd_st1)
        sr1_armed_q <= 1'b1;
      else if (wr_data || !on)
        sr1_armed_q <= 1'b0;
      if (start_go)
        start_tgl_q <= ~start_tgl_q;
      if (wr_data)
        data_byte_q <= wdata_in;
      data_wr_q <= wr_data;
      rd_data_q <= (rd_in && acc_ok) ? rd_mux : 8'h00;
    end
  end
  assign master_q = st1_q.master;

  // ==========================================================
  // request, wake, clock stretch and ack withhold
  // broadcast_hit_flag is not one of the eight request sources
  assign irq_any = ctrl_q.irq_en & ~cpu_mask_in
    & (|{st1_q.ten_bit_header_sent, st1_q.byte_done_flag, st1_q.own_address_hit, st1_q.sb,
         st2_q.af, st2_q.stop_seen_flag, st2_q.arbitration_lost_flag, st2_q.bus_fault_flag});

  // ack, stop, arbitration and fault flags never stretch the clock
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      ack_off_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_any;
      wake_q <= irq_any & (pwr_q == ISE_PWR_WAIT);
      scl_oe_n_q <= ~(st1_d.sb | st1_d.byte_done_flag);
      ack_off_q <= (pwr_d == ISE_PWR_HALT);
    end
  end

  // the clock pin is open drain: only ever pulled low
  logic scl_lo_q;
  always_ff @(posedge core_clk_in)
  begin
    scl_lo_q <= 1'b0;
  end

  assign scl_out = scl_lo_q;
  assign scl_oe_n_out = scl_oe_n_q;
  assign irq_req_out = irq_q;
  assign wake_out = wake_q;
  assign ack_hold_off_out = ack_off_q;
  assign rd_data_out = rd_data_q;
  assign data_byte_out = data_byte_q;
  assign data_wr_out = data_wr_q;

endmodule
`default_nettype wire

// File: common/ise_regs.svh
/*
  Register offsets, field positions, reset values and event indices
  of the two-wire bus status and event block.
  Assumes an 8-bit register port and a bus engine that reports events.
*/
`ifndef ISE_REGS_SVH
`define ISE_REGS_SVH
// ==========================================================
// register offsets
`define ISE_OFF_CTRL 8'h00
`define ISE_OFF_STATUS_ONE 8'h01
`define ISE_OFF_STATUS_TWO 8'h02
`define ISE_OFF_DATA 8'h03
// ==========================================================
// control fields
`define ISE_CTRL_ON 0
`define ISE_CTRL_IRQ_EN 1
`define ISE_CTRL_START 2
`define ISE_CTRL_BCAST_EN 3
`define ISE_CTRL_ACK_EN 4
`define ISE_CTRL_RESET 5'h00
`define ISE_STATUS_TWO_RESET 8'h00
// ==========================================================
// event indices on the link-to-core crossing
`define ISE_EV_START_DONE 0
`define ISE_EV_BYTE_DONE 1
`define ISE_EV_ADDR_HIT 2
`define ISE_EV_TEN_BIT_HEADER_SENT 3
`define ISE_EV_ACK_MISSING 4
`define ISE_EV_STOP_SEEN 5
`define ISE_EV_ARB_LOST 6
`define ISE_EV_BUS_FAULT 7
`define ISE_EV_GC_HIT 8
`define ISE_EV_STOP_ANY 9
`define ISE_NUM_EV 10
`endif

// File: common/ise_pkg.sv
/*
  Types of the two-wire bus status and event block.
  Assumes ise_regs.svh supplies the numbers.
*/
package ise_pkg;
  // control register image, high bit first
  typedef struct packed {
    logic ack_en;
    logic bcast_en;
    logic irq_en;
    logic on;
  } ise_ctrl_t;
  // status one: bits 4:0
  typedef struct packed {
    logic ten_bit_header_sent;
    logic own_address_hit;
    logic byte_done_flag;
    logic master;
    logic sb;
  } ise_st1_t;
  // status two: bits 4:0, upper bits read zero
  typedef struct packed {
    logic af;
    logic stop_seen_flag;
    logic arbitration_lost_flag;
    logic bus_fault_flag;
    logic broadcast_hit_flag;
  } ise_st2_t;
  typedef enum logic [1:0] {ISE_PWR_RUN, ISE_PWR_WAIT, ISE_PWR_HALT} ise_pwr_t;
endpackage

// File: tb/ise_checker.sv
/*
  Checker of the status and event block at its core-side ports.
  Assumes it is bound into ise_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ise_checker
  import ise_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic halt_in,
  input wire logic wait_in,
  input wire logic cpu_mask_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rd_data_out,
  input wire logic irq_req_out,
  input wire logic wake_out,
  input wire logic ack_hold_off_out,
  input wire logic scl_out,
  input wire logic scl_oe_n_out,
  input wire logic [7:0] data_byte_out,
  input wire logic data_wr_out
);
  // ==========================================
  // register port decode; accesses count only outside halt
  wire run_w = !halt_in && !ack_hold_off_out;
  wire ctl_w = addr_in == ADDR_W'(8'h00);
  wire st2_w = addr_in == ADDR_W'(8'h02);
  wire dat_w = addr_in == ADDR_W'(8'h03);
  // ==========================================
  // properties, all on the core clock
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  st2_upper_a:
    assert property ($past(rd_in && st2_w) |-> rd_data_out[7:5] == 3'h0)
    else $error("status two upper bits not zero");
  irq_mask_a:
    assert property ($past(cpu_mask_in) |-> !irq_req_out)
    else $error("request raised while cpu mask set");
  wake_wait_a:
    assert property (wake_out |-> $past(wait_in) || $past(wait_in, 2))
    else $error("wake outside the wait state");
  halt_flag_a:
    assert property (halt_in [*3] |=> ack_hold_off_out)
    else $error("acknowledges not withheld in halt");
  halt_read_a:
    assert property (rd_in && halt_in && ack_hold_off_out
      |=> rd_data_out == 8'h00)
    else $error("register read answered in halt");
  scl_low_a:
    assert property (!scl_oe_n_out |-> !scl_out)
    else $error("clock line driven high");
  data_wr_a:
    assert property (wr_in && dat_w && run_w
      |=> data_wr_out && data_byte_out == $past(wdata_in))
    else $error("data write not passed on");
  off_clear_a:
    assert property (wr_in && ctl_w && !wdata_in[0] && run_w
      ##[1:2] rd_in && st2_w && run_w |=> rd_data_out == 8'h00)
    else $error("flags survive disable");
endmodule
bind ise_top ise_checker #(.ADDR_W(ADDR_W)) u_ise_checker (.core_clk_in,
  .reset_n_in, .halt_in, .wait_in, .cpu_mask_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rd_data_out, .irq_req_out, .wake_out,
  .ack_hold_off_out, .scl_out, .scl_oe_n_out, .data_byte_out,
  .data_wr_out);
`default_nettype wire

// File: tb/ise_bus_peer.sv
/*
  Model of the other parties on the two-wire bus and of the shift
  engine that reports their traffic as one-cycle link pulses.
  Assumes pull-ups on both lines, so idle lines read high.
*/
`timescale 1ns/1ps
`default_nettype none
module ise_bus_peer
(
  input wire logic link_clk_in,
  input wire logic start_req_in,
  output logic scl_out,
  output logic sda_out,
  output logic [7:0] ev_out,
  output logic mid_byte_out
);
  int lag = 0;
  // ==========================================
  // bus actions; every change lands just after a link edge
  task automatic pulse(input int idx);
    @(posedge link_clk_in);
    ev_out[idx] <= 1'b1;
    @(posedge link_clk_in);
    ev_out <= 8'h00;
  endtask
  // each level held two edges so the pin synchroniser sees it
  task automatic drive(input logic c, input logic d);
    @(posedge link_clk_in);
    scl_out <= c;
    sda_out <= d;
    @(posedge link_clk_in);
  endtask
  // stop lowers sda under a low clock first, else it reads as a start
  task automatic cond(input logic stop, input logic mid);
    @(posedge link_clk_in);
    mid_byte_out <= mid;
    if (stop)
    begin
      drive(1'b0, 1'b1);
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
    end
    else
    begin
      drive(1'b1, 1'b0);
      drive(1'b0, 1'b0);
      drive(1'b0, 1'b1);
    end
    drive(1'b1, 1'b1);
    // the pin flops lag two edges; keep the byte flag up that long
    repeat (2) @(posedge link_clk_in);
    mid_byte_out <= 1'b0;
  endtask
  // answer a start request after lag cycles, then report it
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    ev_out = 8'h00;
    mid_byte_out = 1'b0;
    forever
    begin
      @(posedge link_clk_in iff start_req_in);
      repeat (lag) @(posedge link_clk_in);
      cond(1'b0, 1'b0);
      pulse(0);
    end
  end
endmodule
`default_nettype wire

// File: tb/testbench.sv
/*
  Self-checking bench of the status and event block.
  Assumes the bus peer model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  import ise_pkg::*;
  logic core_clk_in = 0, link_clk_in = 0, reset_n_in = 0;
  logic wait_in = 0, halt_in = 0, cpu_mask_in = 0, wr_in = 0, rd_in = 0;
  logic master_rx_in = 0, ack_slot_in = 0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, exp_v;
  logic [7:0] exp_q[$];
  logic rd_q = 0;
  int error_cnt = 0, compares = 0, cyc = 0;
  wire logic scl_in, sda_in, mid_byte_in, scl_out, scl_oe_n_out;
  wire logic irq_req_out, wake_out, ack_hold_off_out, start_req_out;
  wire logic data_wr_out;
  wire logic [7:0] ev, rd_data_out, data_byte_out;
  // core clock, and a link clock of unrelated phase
  always #20 core_clk_in = ~core_clk_in;
  initial #7 forever #62.5 link_clk_in = ~link_clk_in;
  ise_top u_ise_top (.core_clk_in, .reset_n_in, .link_clk_in, .scl_in,
    .scl_out, .scl_oe_n_out, .sda_in, .ev_start_done_in(ev[0]),
    .ev_byte_done_in(ev[1]), .ev_addr_hit_in(ev[2]), .ev_ten_bit_header_sent_in(ev[3]),
    .ev_ack_missing_in(ev[4]), .ev_arb_lost_in(ev[5]),
    .ev_gc_addr_in(ev[6]), .ev_ack_seen_in(ev[7]), .mid_byte_in,
    .master_rx_in, .ack_slot_in, .wait_in, .halt_in,
    .cpu_mask_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rd_data_out,
    .irq_req_out, .wake_out, .ack_hold_off_out, .start_req_out,
    .data_byte_out, .data_wr_out);
  ise_bus_peer u_ise_bus_peer (.link_clk_in, .start_req_in(start_req_out),
    .scl_out(scl_in), .sda_out(sda_in), .ev_out(ev),
    .mid_byte_out(mid_byte_in));
  // ==========================================
  // register port: one-cycle strobes; reads note their answer
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // one status-two event: flag and request, clock line left alone
  task automatic ev_check(input int idx, input logic [7:0] e);
    u_ise_bus_peer.pulse(idx);
    gap(20);
    @(negedge core_clk_in);
    `CHK("irq", 1'b1, irq_req_out)
    `CHK("scl hold", 1'b1, scl_oe_n_out)
    rd_reg(8'h02, e);
    rd_reg(8'h02, 8'h00);
  endtask
  // read answers stand one cycle: match each with the oldest note
  always @(posedge core_clk_in)
  begin
    rd_q <= rd_in;
    if (rd_q)
    begin
      exp_v = exp_q.pop_front();
      `CHK("read", exp_v, rd_data_out)
    end
  end
  // ==========================================
  // hang guard and verdict
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================
  // main sequence; the link side takes reset through its own flops
  initial
  begin
    void'($urandom(32'h5C67));
    gap(6);
    reset_n_in <= 1'b1;
    rd_reg(8'h02, 8'h00);
    rd_reg(8'h04 + 8'($urandom_range(0, 250)), 8'h00);
    wr_reg(8'h00, 8'h1B);
    rd_reg(8'h00, 8'h1B);
    // slow start answer; a data write ahead of the status read
    u_ise_bus_peer.lag = 6;
    wr_reg(8'h00, 8'h1F);
    rd_reg(8'h01, 8'h02);
    wr_reg(8'h03, 8'($urandom));
    gap(100);
    wr_reg(8'h03, 8'($urandom));
    rd_reg(8'h01, 8'h03);
    @(negedge core_clk_in);
    `CHK("irq", 1'b1, irq_req_out)
    `CHK("scl hold", 1'b0, scl_oe_n_out)
    wr_reg(8'h03, 8'($urandom));
    rd_reg(8'h01, 8'h02);
    ev_check(4, 8'h10);
    ev_check(5, 8'h04);
    rd_reg(8'h01, 8'h00);
    // no arbitration in the ack bit of a master receive
    master_rx_in <= 1'b1;
    ack_slot_in <= 1'b1;
    u_ise_bus_peer.pulse(5);
    gap(20);
    rd_reg(8'h02, 8'h00);
    ack_slot_in <= 1'b0;
    ev_check(5, 8'h04);
    master_rx_in <= 1'b0;
    // byte, address and header events; the byte flag holds the clock until cleared
    u_ise_bus_peer.pulse(1);
    u_ise_bus_peer.pulse(2);
    u_ise_bus_peer.pulse(3);
    gap(20);
    @(negedge core_clk_in);
    `CHK("btf hold", 1'b0, scl_oe_n_out)
    rd_reg(8'h01, 8'h1C);
    wr_reg(8'h03, 8'($urandom));
    rd_reg(8'h01, 8'h00);
    // misplaced stop, then the master's clean stop to resync
    u_ise_bus_peer.cond(1'b1, 1'b1);
    u_ise_bus_peer.cond(1'b1, 1'b0);
    gap(20);
    rd_reg(8'h02, 8'h02);
    rd_reg(8'h02, 8'h00);
    // general call survives reads, falls at a stop after an ack
    u_ise_bus_peer.pulse(6);
    gap(20);
    rd_reg(8'h02, 8'h01);
    rd_reg(8'h02, 8'h01);
    u_ise_bus_peer.pulse(7);
    u_ise_bus_peer.cond(1'b1, 1'b0);
    gap(20);
    rd_reg(8'h02, 8'h08);
    rd_reg(8'h02, 8'h00);
    // prompt start answer, then mask, wait and halt
    u_ise_bus_peer.lag = 0;
    wr_reg(8'h00, 8'h1F);
    gap(100);
    rd_reg(8'h01, 8'h03);
    cpu_mask_in <= 1'b1;
    gap(3);
    @(negedge core_clk_in);
    `CHK("masked irq", 1'b0, irq_req_out)
    gap(1);
    cpu_mask_in <= 1'b0;
    wait_in <= 1'b1;
    gap(5);
    @(negedge core_clk_in);
    `CHK("wake", 1'b1, wake_out)
    gap(1);
    wait_in <= 1'b0;
    halt_in <= 1'b1;
    u_ise_bus_peer.pulse(4);
    gap(20);
    @(negedge core_clk_in);
    `CHK("halt", 1'b1, ack_hold_off_out)
    rd_reg(8'h02, 8'h00);
    halt_in <= 1'b0;
    gap(20);
    rd_reg(8'h02, 8'h10);
    // disable with a flag pending
    u_ise_bus_peer.pulse(4);
    gap(20);
    wr_reg(8'h00, 8'h00);
    rd_reg(8'h02, 8'h00);
    rd_reg(8'h01, 8'h00);
    gap(2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
